/* File: bench/serial_peer.sv */
// =====================================================================
// Remote transceiver: 8N1 sender, character catcher
// =====================================================================
module serial_peer #(
  parameter int BIT_CYC = 32  // mclk cycles per bit at the chosen baud
) (
  input  wire logic mclk,     // System clock
  input  wire logic line_in,  // Core transmit line
  output logic      line_out  // Core receive line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;      // Last character caught
  logic       stop_ok;  // Its stop bit was high
  initial line_out = 1'b1;  // Idle high
  // Sends start, eight bits LSB first, then one high stop
  task automatic send(input logic [7:0] d);
    @(posedge mclk) line_out <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge mclk);
  endtask : send
  // Samples mid-bit, so a small baud skew does not matter
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        got[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge mclk);
      stop_ok = line_in;
    end
  end
endmodule : serial_peer

/* File: bench/tb.sv */
// =====================================================================
// Register-level bench
// =====================================================================
module tb
  import async_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic [7:0]  wdata = 8'h00, rdata, q;
  logic        rxl, txl, tx_irq, rx_irq, tick_irq;
  logic        pin_sel = 1'b1, gpio = 1'b0;
  int          num_errors = 0, tests_run = 0;
  async_serial_port_core async_serial_port_core_i (.mclk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .pin_func_sel(pin_sel), .gpio_out_bit(gpio), .serial_rx_pin(rxl),
    .serial_tx_pin(txl), .tx_ready_irq(tx_irq), .rx_ready_irq(rx_irq),
    .baud_tick_irq(tick_irq));
  serial_peer serial_peer_i (.mclk(mclk), .line_in(txl), .line_out(rxl));
  initial forever #50 mclk = ~mclk;
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [23:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [23:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Bounded wait for a one-cycle request pulse
  task automatic wait_irq(input int k, input string nm);
    logic hit = 1'b0;
    repeat (600) if (hit !== 1'b1) begin
      @(posedge mclk);
      hit = (k == 0) ? tx_irq : (k == 1) ? rx_irq : tick_irq;
    end
    check(nm, {7'h00, hit}, 8'h01);
  endtask : wait_irq
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Watchdog: the whole sequence needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(ADDR_CONTROL, q);
    check("control", q, 8'h00);
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h00);
    rd_reg(24'h600307, q);
    check("unmapped", q, 8'h00);
    // Reload 0xFF: tick every 2 mclk, 32 mclk per bit
    wr_reg(ADDR_BAUDREL, 8'hFF);
    wr_reg(ADDR_BAUDCNT, 8'hFF);
    wr_reg(ADDR_BAUDCON, 8'h14);
    wait_irq(2, "baud_tick");
    wr_reg(ADDR_CONTROL, 8'h01);
    wr_reg(ADDR_BUF, 8'hA5);
    wait_irq(0, "tx_ready");
    repeat (400) @(posedge mclk);
    check("tx_char", serial_peer_i.got, 8'hA5);
    check("tx_stop", {7'h00, serial_peer_i.stop_ok}, 8'h01);
    // Two characters with no read between: overrun
    for (int i = 0; i < 2; i++) begin
      fork
        serial_peer_i.send(i ? 8'h5A : 8'h3C);
        wait_irq(1, "rx_ready");
      join
    end
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h1A);
    rd_reg(ADDR_BUF, q);
    check("rx_buf", q, 8'h5A);
    wr_reg(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h1A);
    wr_reg(ADDR_STATUS, 8'hFF);
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h00);
    // Loopback, 7 bits, even parity, one stop: receiver hears the transmitter
    wr_reg(ADDR_CONTROL, 8'h1F);
    wr_reg(ADDR_TEST, 8'h01);
    wr_reg(ADDR_BUF, 8'h57);
    wait_irq(1, "loop_rx");
    rd_reg(ADDR_BUF, q);
    check("loop_buf", q, 8'h57);
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h18);
    // Forced parity and framing errors on the next looped character
    wr_reg(ADDR_STATUS, 8'hFF);
    wr_reg(ADDR_TEST, 8'h07);
    wr_reg(ADDR_BUF, 8'h2A);
    wait_irq(1, "loop_rx");
    rd_reg(ADDR_STATUS, q);
    check("status", q, 8'h1D);
    // Port bit owns the tx pin once the serial function is off
    @(posedge mclk);
    pin_sel <= 1'b0;
    @(posedge mclk);
    check("tx_pin", {7'h00, txl}, 8'h00);
    print_verdict();
  end
endmodule : tb

/* File: design/async_serial_pkg.sv */
// =====================================================================
// Shared constants for the asynchronous serial port
// =====================================================================
package async_serial_pkg;
  // =====================================================================
  // Register offsets (byte addresses on the register port)
  // =====================================================================
  localparam logic [23:0] ADDR_BUF     = 24'h600300; // Rx read / Tx write
  localparam logic [23:0] ADDR_STATUS  = 24'h600301; // Flags, write 1 clears
  localparam logic [23:0] ADDR_CONTROL = 24'h600302; // Frame format
  localparam logic [23:0] ADDR_BAUDCON = 24'h600303; // Baud generator control
  localparam logic [23:0] ADDR_BAUDCNT = 24'h600304; // Baud counter
  localparam logic [23:0] ADDR_BAUDREL = 24'h600305; // Baud reload value
  localparam logic [23:0] ADDR_TEST    = 24'h600306; // Loopback test control

  // =====================================================================
  // Reset values
  // =====================================================================
  localparam logic [7:0] RST_BYTE = 8'h00; // Every register clears to zero

  // =====================================================================
  // Field positions
  // =====================================================================
  localparam int CTL_RX_EN   = 0; // receive_enable_bit
  localparam int CTL_STOP1   = 1; // tx_stop_count_select
  localparam int CTL_EVEN    = 2; // parity_sense_select
  localparam int CTL_PAR_EN  = 3; // parity_include_enable
  localparam int CTL_LEN7    = 4; // char_length_select
  localparam logic [7:0] CTL_MASK = 8'h1F; // Implemented control bits
  localparam int ST_FERR     = 0; // Framing error flag
  localparam int ST_OERR     = 1; // Overrun error flag
  localparam int ST_PERR     = 2; // Parity error flag
  localparam int ST_RXRDY    = 3; // Receive ready flag
  localparam int ST_TXRDY    = 4; // Transmit ready flag
  localparam int BC_RUN      = 2; // Counter run
  localparam int BC_OVF      = 3; // Overflow flag, write 1 clears
  localparam int BC_MODE     = 4; // 1: serves the serial port
  localparam int TS_LOOP     = 0; // Loop transmit line to receiver
  localparam int TS_FPERR    = 1; // Force parity error in loopback
  localparam int TS_FFERR    = 2; // Force framing error in loopback
  localparam logic [7:0] TS_MASK = 8'h07; // Implemented test bits

  // =====================================================================
  // Timing counts in baud ticks
  // =====================================================================
  localparam logic [3:0] OVS_LAST = 4'hF; // 16 ticks per bit
  localparam logic [3:0] OVS_MID  = 4'h7; // Middle of the start bit

  // Frame sequencer states, Gray along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    FR_IDLE  = 3'h0,
    FR_START = 3'h1,
    FR_DATA  = 3'h3,
    FR_PAR   = 3'h2,
    FR_STOP  = 3'h6
  } frame_st_t;
endpackage : async_serial_pkg

/* File: design/async_serial_port_core.sv */
// =====================================================================
// Notes on behaviour
// - Start element before data, stop after
// - Length bit: 1 gives 7, 0 gives 8
// - Stop select: 1 gives one, 0 two
// - Parity enable adds and checks parity bit
// - Sense bit: 1 even, 0 odd parity
// - Receiver works only while enabled
// - Control register resets to zero
// - Buffer read gives receive, write transmit
// - Completion loads buffer, raises receive request
// - Receive buffer holds until next completion
// - Buffer moved to shifter raises transmit request
// - Detect parity, framing and overrun errors
// - Baud generator has its own request
// - Serial lines only when pin function selected
// - Flags cleared by writing one only
// - Overrun still overwrites the receive buffer
// - Stop sampled low flags framing error
// - Overflow reloads counter, counting continues
// =====================================================================
module async_serial_port_core
  import async_serial_pkg::*;
(
  input  wire logic        mclk,          // System clock
  input  wire logic        rst,           // Asynchronous reset
  input  wire logic [23:0] addr,          // Register address
  input  wire logic [7:0]  wdata,         // Write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [7:0]  rdata,         // Read data, cycle after rd
  input  wire logic        pin_func_sel,  // 1: pins carry the serial lines
  input  wire logic        gpio_out_bit,  // Port bit sharing the tx pin
  input  wire logic        serial_rx_pin, // Receive line
  output logic             serial_tx_pin, // Transmit line or port bit
  output logic             tx_ready_irq,  // Transmit ready request pulse
  output logic             rx_ready_irq,  // Receive ready request pulse
  output logic             baud_tick_irq  // Baud generator request pulse
);
  // =====================================================================
  // Register file
  // =====================================================================
  logic [7:0] ctrl_ff;    // serial_control
  logic [7:0] test_ff;    // loopback_test_control
  logic [4:0] bcon_ff;    // baud_control
  logic [4:0] st_ff;      // serial_status
  logic [7:0] rdata_ff;   // Registered read data
  logic [7:0] tx_buf_ff;  // Transmit buffer
  logic       tx_full_ff; // Transmit buffer holds a byte
  logic [7:0] rx_buf_ff;  // Receive buffer
  logic       unread_ff;  // Receive buffer not yet read

  baud_if bif ();

  baud_generator u_baud (
    .mclk (mclk),
    .rst  (rst),
    .bif  (bif)
  );

  // Address decode shared by all write paths
  function automatic logic hit(input logic [23:0] a, input logic [23:0] r);
    hit = (a == r);
  endfunction : hit

  // Parity bit over 7 or 8 data bits, even or odd sense
  function automatic logic par_bit(input logic [7:0] d, input logic len7,
                                   input logic even);
    logic x;
    x = ^d[6:0] ^ (d[7] & ~len7);
    par_bit = even ? x : ~x;
  endfunction : par_bit

  logic wr_st;   // Status write
  logic tick_en; // Baud tick that drives the serial port
  assign wr_st   = wr && hit(addr, ADDR_STATUS);
  assign tick_en = bif.tick && bcon_ff[BC_MODE];

  assign bif.cnt_we  = wr && hit(addr, ADDR_BAUDCNT);
  assign bif.rel_we  = wr && hit(addr, ADDR_BAUDREL);
  assign bif.wdata   = wdata;
  assign bif.clk_sel = bcon_ff[1:0];
  assign bif.run     = bcon_ff[BC_RUN];

  // Control and test registers; reserved bits are not stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= RST_BYTE;
      test_ff <= RST_BYTE;
    end else if (wr && hit(addr, ADDR_CONTROL)) begin
      ctrl_ff <= wdata & CTL_MASK;
    end else if (wr && hit(addr, ADDR_TEST)) begin
      test_ff <= wdata & TS_MASK;
    end
  end

  // Baud control; the overflow flag is set by hardware, set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bcon_ff <= 5'h00;
    end else if (wr && hit(addr, ADDR_BAUDCON)) begin
      bcon_ff[2:0]     <= wdata[2:0];
      bcon_ff[BC_MODE] <= wdata[BC_MODE];
      bcon_ff[BC_OVF]  <= bif.tick | (bcon_ff[BC_OVF] & ~wdata[BC_OVF]);
    end else if (bif.tick) begin
      bcon_ff[BC_OVF] <= 1'b1;
    end
  end

  // =====================================================================
  // Transmitter
  // =====================================================================
  frame_st_t  tx_st_ff;   // Transmit sequencer
  logic [3:0] tx_os_ff;   // Ticks within the bit
  logic [7:0] tx_sh_ff;   // Transmit shift register
  logic [2:0] tx_bit_ff;  // Data bit index
  logic       tx_stop_ff; // Second stop bit pending
  logic       tx_line_ff; // Line level
  logic       tx_load;    // Buffer moves to shifter
  logic [2:0] last_bit;   // Index of the last data bit
  logic [7:0] tx_char_ff; // Character in flight, parity is taken over it

  assign tx_load  = (tx_st_ff == FR_IDLE) && tx_full_ff;
  assign last_bit = ctrl_ff[CTL_LEN7] ? 3'h6 : 3'h7;

  // Transmit buffer; a new write in the load cycle is kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_buf_ff  <= RST_BYTE;
      tx_full_ff <= 1'b0;
    end else if (wr && hit(addr, ADDR_BUF)) begin
      tx_buf_ff  <= wdata;
      tx_full_ff <= 1'b1;
    end else if (tx_load) begin
      tx_full_ff <= 1'b0;
    end
  end

  // Transmit framing, own state apart from the receiver
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_st_ff   <= FR_IDLE;
      tx_os_ff   <= 4'h0;
      tx_sh_ff   <= RST_BYTE;
      tx_bit_ff  <= 3'h0;
      tx_stop_ff <= 1'b0;
      tx_line_ff <= 1'b1;
    end else if (tx_load) begin
      tx_sh_ff   <= tx_buf_ff;
      tx_st_ff   <= FR_START;
      tx_os_ff   <= 4'h0;
      tx_bit_ff  <= 3'h0;
      tx_line_ff <= 1'b0;
    end else if (tick_en && tx_st_ff != FR_IDLE) begin
      tx_os_ff <= tx_os_ff + 4'h1;
      if (tx_os_ff == OVS_LAST) begin
        case (tx_st_ff)
          FR_START: begin
            tx_st_ff   <= FR_DATA;
            tx_line_ff <= tx_sh_ff[0];
          end
          FR_DATA: begin
            tx_bit_ff <= tx_bit_ff + 3'h1;
            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
            if (tx_bit_ff == last_bit) begin
              // Parity first if enabled, then stop elements
              tx_stop_ff <= ~ctrl_ff[CTL_STOP1];
              if (ctrl_ff[CTL_PAR_EN]) begin
                tx_st_ff   <= FR_PAR;
                tx_line_ff <= par_bit(tx_char_ff, ctrl_ff[CTL_LEN7],
                                      ctrl_ff[CTL_EVEN]);
              end else begin
                tx_st_ff   <= FR_STOP;
                tx_line_ff <= 1'b1;
              end
            end else begin
              tx_line_ff <= tx_sh_ff[1];
            end
          end
          FR_PAR: begin
            tx_st_ff   <= FR_STOP;
            tx_line_ff <= 1'b1;
          end
          FR_STOP: begin
            if (tx_stop_ff) begin
              tx_stop_ff <= 1'b0;
            end else begin
              tx_st_ff <= FR_IDLE;
            end
          end
          default: begin
            tx_st_ff   <= FR_IDLE;
            tx_line_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // Copy of the character in flight; the buffer may be rewritten meanwhile
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_char_ff <= RST_BYTE;
    end else if (tx_load) begin
      tx_char_ff <= tx_buf_ff;
    end
  end

  // =====================================================================
  // Receiver
  // =====================================================================
  frame_st_t  rx_st_ff;   // Receive sequencer
  logic [3:0] rx_os_ff;   // Ticks within the bit
  logic [7:0] rx_sh_ff;   // Receive shift register
  logic [2:0] rx_bit_ff;  // Data bit index
  logic       rx_pbit_ff; // Received parity bit
  logic       rx_done_ff; // Character complete pulse
  logic [7:0] rx_word_ff; // Completed character
  logic       rx_perr_ff; // Parity error of that character
  logic       rx_ferr_ff; // Framing error of that character
  logic       rx_in;      // Line seen by the receiver
  logic [7:0] rx_word;    // Shifter aligned for 7 or 8 bits
  logic       loop;       // Loopback active

  assign loop    = test_ff[TS_LOOP];
  assign rx_in   = loop ? tx_line_ff : (pin_func_sel ? serial_rx_pin : 1'b1);
  assign rx_word = ctrl_ff[CTL_LEN7] ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff;

  // Receive framing; disabling aborts a character in progress
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_st_ff   <= FR_IDLE;
      rx_os_ff   <= 4'h0;
      rx_sh_ff   <= RST_BYTE;
      rx_bit_ff  <= 3'h0;
      rx_pbit_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_word_ff <= RST_BYTE;
      rx_perr_ff <= 1'b0;
      rx_ferr_ff <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      if (!ctrl_ff[CTL_RX_EN]) begin
        rx_st_ff <= FR_IDLE;
      end else if (rx_st_ff == FR_IDLE) begin
        if (!rx_in) begin
          rx_st_ff  <= FR_START;
          rx_os_ff  <= 4'h0;
          rx_bit_ff <= 3'h0;
        end
      end else if (tick_en) begin
        rx_os_ff <= rx_os_ff + 4'h1;
        case (rx_st_ff)
          FR_START: begin
            // Recheck mid start bit so a glitch is not a character
            if (rx_os_ff == OVS_MID) begin
              rx_os_ff <= 4'h0;
              rx_st_ff <= rx_in ? FR_IDLE : FR_DATA;
            end
          end
          FR_DATA: begin
            if (rx_os_ff == OVS_LAST) begin
              rx_sh_ff  <= {rx_in, rx_sh_ff[7:1]};
              rx_bit_ff <= rx_bit_ff + 3'h1;
              if (rx_bit_ff == last_bit) begin
                rx_st_ff <= ctrl_ff[CTL_PAR_EN] ? FR_PAR : FR_STOP;
              end
            end
          end
          FR_PAR: begin
            if (rx_os_ff == OVS_LAST) begin
              rx_pbit_ff <= rx_in;
              rx_st_ff   <= FR_STOP;
            end
          end
          FR_STOP: begin
            if (rx_os_ff == OVS_LAST) begin
              rx_st_ff   <= FR_IDLE;
              rx_done_ff <= 1'b1;
              rx_word_ff <= rx_word;
              rx_perr_ff <= (ctrl_ff[CTL_PAR_EN] && rx_pbit_ff !=
                             par_bit(rx_word, ctrl_ff[CTL_LEN7], ctrl_ff[CTL_EVEN]))
                            || (loop && test_ff[TS_FPERR]);
              rx_ferr_ff <= !rx_in || (loop && test_ff[TS_FFERR]);
            end
          end
          default: begin
            rx_st_ff <= FR_IDLE;
          end
        endcase
      end
    end
  end

  // Receive buffer changes only on completion, even over unread data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_buf_ff <= RST_BYTE;
    end else if (rx_done_ff) begin
      rx_buf_ff <= rx_word_ff;
    end
  end

  // Unread marker; a completion beats a read in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unread_ff <= 1'b0;
    end else if (rx_done_ff) begin
      unread_ff <= 1'b1;
    end else if (rd && hit(addr, ADDR_BUF)) begin
      unread_ff <= 1'b0;
    end
  end

  // =====================================================================
  // Status flags: hardware sets, software writes 1 to clear, set wins
  // =====================================================================
  logic [4:0] st_set; // Flags raised this cycle
  logic [4:0] st_clr; // Flags cleared by software
  always_comb begin
    st_set           = 5'h00;
    st_set[ST_TXRDY] = tx_load;
    st_set[ST_RXRDY] = rx_done_ff;
    st_set[ST_PERR]  = rx_done_ff && rx_perr_ff;
    st_set[ST_OERR]  = rx_done_ff && unread_ff;
    st_set[ST_FERR]  = rx_done_ff && rx_ferr_ff;
    st_clr           = wr_st ? wdata[4:0] : 5'h00;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= 5'h00;
    end else begin
      st_ff <= (st_ff & ~st_clr) | st_set;
    end
  end

  // Request pulses, one system clock wide
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ready_irq  <= 1'b0;
      rx_ready_irq  <= 1'b0;
      baud_tick_irq <= 1'b0;
    end else begin
      tx_ready_irq  <= tx_load;
      rx_ready_irq  <= rx_done_ff;
      baud_tick_irq <= bif.tick;
    end
  end

  // Read mux, answer in the next cycle; unmapped reads zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= RST_BYTE;
    end else if (rd) begin
      case (addr)
        ADDR_BUF:     rdata_ff <= rx_buf_ff;
        ADDR_STATUS:  rdata_ff <= {3'h0, st_ff};
        ADDR_CONTROL: rdata_ff <= ctrl_ff;
        ADDR_BAUDCON: rdata_ff <= {3'h0, bcon_ff};
        ADDR_BAUDCNT: rdata_ff <= bif.cnt;
        ADDR_BAUDREL: rdata_ff <= bif.rel;
        ADDR_TEST:    rdata_ff <= test_ff;
        default:      rdata_ff <= RST_BYTE;
      endcase
    end else begin
      rdata_ff <= RST_BYTE;
    end
  end

  assign rdata         = rdata_ff;
  assign serial_tx_pin = pin_func_sel ? tx_line_ff : gpio_out_bit;

  // =====================================================================
  // Checks
  // =====================================================================
  property p_ctrl_reset;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> ctrl_ff == RST_BYTE;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not clear");

  property p_tx_start;
    @(posedge mclk) disable iff (rst) tx_load |=> !tx_line_ff && st_ff[ST_TXRDY];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start or ready");

  property p_rx_load;
    @(posedge mclk) disable iff (rst)
      rx_done_ff |=> st_ff[ST_RXRDY] && rx_buf_ff == $past(rx_word_ff);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("receive not loaded");

  property p_rx_hold;
    @(posedge mclk) disable iff (rst) !rx_done_ff |=> $stable(rx_buf_ff);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("buffer changed");

  property p_overrun;
    @(posedge mclk) disable iff (rst) rx_done_ff && unread_ff |=> st_ff[ST_OERR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_framing;
    @(posedge mclk) disable iff (rst) rx_done_ff && rx_ferr_ff |=> st_ff[ST_FERR];
  endproperty
  a_framing: assert property (p_framing) else $error("framing missed");

  property p_rx_off;
    @(posedge mclk) disable iff (rst) !ctrl_ff[CTL_RX_EN] |=> rx_st_ff == FR_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver not idle");

  property p_w1c;
    @(posedge mclk) disable iff (rst)
      wr_st && wdata[ST_TXRDY] && !tx_load |=> !st_ff[ST_TXRDY];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_read_buf;
    @(posedge mclk) disable iff (rst)
      rd && addr == ADDR_BUF |=> rdata == $past(rx_buf_ff);
  endproperty
  a_read_buf: assert property (p_read_buf) else $error("bad buffer read");
endmodule : async_serial_port_core

/* File: design/baud_generator.sv */
// =====================================================================
// Baud generator: prescaled 8-bit auto-reload counter
// =====================================================================
module baud_generator
  import async_serial_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  baud_if.gen      bif
);
  logic [3:0] pre_ff; // Prescaler count
  logic [7:0] cnt_ff; // Baud counter
  logic [7:0] rel_ff; // Reload value
  logic       tick_ff; // Overflow pulse

  // Last prescaler count for a divide by 2, 4, 8 or 16
  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    pre_limit = 4'(({1'b0, 4'h2} << sel) - 5'h01);
  endfunction : pre_limit

  logic pre_end; // Prescaler wraps this cycle
  assign pre_end = (pre_ff >= pre_limit(bif.clk_sel));

  // Prescaler only runs while counting, so a restart is phase clean
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_ff <= 4'h0;
    end else if (!bif.run || pre_end) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  // Reload value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rel_ff <= RST_BYTE;
    end else if (bif.rel_we) begin
      rel_ff <= bif.wdata;
    end
  end

  // Counter; an overflow beats a software write in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= RST_BYTE;
      tick_ff <= 1'b0;
    end else if (bif.run && pre_end && cnt_ff == 8'hFF) begin
      cnt_ff  <= rel_ff;
      tick_ff <= 1'b1;
    end else begin
      tick_ff <= 1'b0;
      if (bif.cnt_we) begin
        cnt_ff <= bif.wdata;
      end else if (bif.run && pre_end) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign bif.cnt  = cnt_ff;
  assign bif.rel  = rel_ff;
  assign bif.tick = tick_ff;

  property p_reload;
    @(posedge mclk) disable iff (rst) tick_ff |-> cnt_ff == $past(rel_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_no_tick_stopped;
    @(posedge mclk) disable iff (rst) !bif.run |=> !tick_ff;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped) else $error("tick while stopped");
endmodule : baud_generator

/* File: design/baud_if.sv */
// =====================================================================
// Link between the core and its baud generator
// =====================================================================
interface baud_if;
  logic       cnt_we;  // Software write to the counter
  logic       rel_we;  // Software write to the reload value
  logic [7:0] wdata;   // Write data for either
  logic [1:0] clk_sel; // Prescale select, 2 to 16 system clocks
  logic       run;     // Counting enabled
  logic [7:0] cnt;     // Counter value for read back
  logic [7:0] rel;     // Reload value for read back
  logic       tick;    // One-cycle overflow pulse
  modport gen  (input cnt_we, rel_we, wdata, clk_sel, run, output cnt, rel, tick);
  modport core (output cnt_we, rel_we, wdata, clk_sel, run, input cnt, rel, tick);
endinterface : baud_if
